// ### ldf_diag_flags.v
// per-channel diagnostic flags of a three-channel led buck driver
//
// Contract
// [R1] set toggle flag on any dimming level change
// [R2] any diag2 write clears all toggle flags
// [R3] toggle flags in diag2 bits 2:0
// [R4] headroom check gates channel off, sets flag
// [R5] resume switching once headroom recovers
// [R6] headroom flags stay until diag3 write
// [R7] cleared flags may re-set from stale sample
// [R8] set current-reached when target current reached
// [R9] clear on dim fall, supply uv, copy pulse
// [R10] clear after gate high over 1 ms
// [R11] diag3: cr bits 5:3, headroom 2:0, 7:6 zero
// [R12] block gate turn-on during bootstrap undervoltage
// [R13] bootstrap uv turns channel off, sticky flag
// [R14] write one clears boot flag, zero keeps
// [R15] cleared boot flag re-enables gate drive
// [R16] boot register bits 2:0, 7:3 zero
// [R17] copy pulse updates result, clears live flag
// [R18] set wins over a same-cycle clear
`timescale 1ns/10ps
`include "ldf_defines.vh"
module ldf_diag_flags (
	input wire clk,
	input wire arst_n,
	input wire [2:0] dimInput,
	input wire [2:0] channelOn,
	input wire inputSupplyOk,
	input wire [2:0] headroomLow,
	input wire [2:0] targetReached,
	input wire [2:0] switchNodeOff,
	input wire [2:0] bootstrapBelowUv,
	input wire [2:0] gateRequest,
	input wire wrEn,
	input wire rdEn,
	input wire [7:0] addr,
	input wire [7:0] wrData,
	output wire [7:0] rdData,
	output reg [2:0] gateDrive_r,
	output reg [2:0] currentReachedResult_r,
	output reg [2:0] copyPulseRequest_r
);
	////////////////////////////////////////////////////////////////////////////////
	reg [2:0] dimPrev_r;
	reg [2:0] toggleFlag_r;
	reg [2:0] toggleFlag_nxt;
	reg [2:0] headroomFlag_r;
	reg [2:0] headroomFlag_nxt;
	reg [2:0] headroomHold_r;
	reg [2:0] crLive_r;
	reg [2:0] crLive_nxt;
	reg [2:0] bootFlag_r;
	reg [2:0] bootFlag_nxt;
	reg supplyPrev_r;
	reg [2:0] gateDrive_nxt;
	reg [7:0] rdWord;
	wire [2:0] gateLong;
	wire [2:0] dimEdge;
	wire [2:0] dimFall;
	wire [2:0] headroomEvt;
	wire [2:0] bootEvt;
	wire supplyFall;
	wire wrDiag2;
	wire wrDiag3;
	wire wrBoot;
	wire wrCopy;

	// one decode function for all write address matches
	function hit;
		input [7:0] a;
		input [7:0] refAddr;
		begin
			hit = (a == refAddr);
		end
	endfunction

	assign wrDiag2 = wrEn && hit(addr, `LDF_ADDR_DIAG2);
	assign wrDiag3 = wrEn && hit(addr, `LDF_ADDR_DIAG3);
	assign wrBoot = wrEn && hit(addr, `LDF_ADDR_BOOT);
	assign wrCopy = wrEn && hit(addr, `LDF_ADDR_COPY);

	////////////////////////////////////////////////////////////////////////////////
	// edge detection on the dimming pins and the supply status
	assign dimEdge = dimInput ^ dimPrev_r;
	assign dimFall = dimPrev_r & ~dimInput;
	assign supplyFall = supplyPrev_r & ~inputSupplyOk;
	// headroom monitored only while channel on and supply ok
	assign headroomEvt = headroomLow & channelOn & {3{inputSupplyOk}}; // see [R4]
	// bootstrap compared only while the switch node is off
	assign bootEvt = bootstrapBelowUv & switchNodeOff; // see [R12]

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dimPrev_r <= 3'h0;
			supplyPrev_r <= 1'b0;
			headroomHold_r <= 3'h0;
		end else begin
			dimPrev_r <= dimInput;
			supplyPrev_r <= inputSupplyOk;
			// sample only while monitored; an off channel keeps its last sample
			if (inputSupplyOk) begin
				headroomHold_r <= (headroomLow & channelOn) | (headroomHold_r & ~channelOn); // see [R7]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// gate-high timers, one per channel; long count clears and blocks the live current-reached flag
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : gTimer
			reg [16:0] cnt_r;
			always @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					cnt_r <= 17'h00000;
				end else if (gateDrive_r[g] && dimInput[g]) begin
					if (cnt_r != 17'h1FFFF) begin
						cnt_r <= cnt_r + 17'h00001;
					end
				end else begin
					cnt_r <= 17'h00000;
				end
			end
			// held while over the limit so the live flag cannot re-set meanwhile
			assign gateLong[g] = (cnt_r >= `LDF_GATE_MAX_CYC); // see [R10]
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// next-state of all flags; set terms applied last so they win
	always @* begin
		toggleFlag_nxt = toggleFlag_r;
		if (wrDiag2) begin
			toggleFlag_nxt = 3'h0; // see [R2]
		end
		toggleFlag_nxt = toggleFlag_nxt | dimEdge; // see [R1] see [R18]

		headroomFlag_nxt = headroomFlag_r;
		if (wrDiag3) begin
			headroomFlag_nxt = 3'h0; // see [R6]
			headroomFlag_nxt = (~channelOn | {3{~inputSupplyOk}}) & headroomHold_r; // see [R7]
		end
		headroomFlag_nxt = headroomFlag_nxt | headroomEvt; // see [R4] see [R18]

		crLive_nxt = crLive_r;
		crLive_nxt = crLive_nxt & ~dimFall & ~copyPulseRequest_r & ~gateLong; // see [R9] see [R10]
		if (supplyFall) begin
			crLive_nxt = 3'h0; // see [R9]
		end
		crLive_nxt = crLive_nxt | (targetReached & dimInput & ~gateLong); // see [R8]

		bootFlag_nxt = bootFlag_r;
		if (wrBoot) begin
			bootFlag_nxt = bootFlag_r & ~wrData[2:0]; // see [R14]
		end
		bootFlag_nxt = bootFlag_nxt | bootEvt; // see [R13] see [R18]

		// gate off on headroom or boot fault; returns when both clear
		gateDrive_nxt = gateRequest & channelOn & {3{inputSupplyOk}}
			& ~headroomLow & ~bootFlag_nxt & ~bootEvt; // see [R5] see [R12] see [R15]
	end

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			toggleFlag_r <= `LDF_FLAG_RESET;
			headroomFlag_r <= `LDF_FLAG_RESET;
			crLive_r <= `LDF_FLAG_RESET;
			bootFlag_r <= `LDF_FLAG_RESET;
			gateDrive_r <= 3'h0;
		end else begin
			toggleFlag_r <= toggleFlag_nxt;
			headroomFlag_r <= headroomFlag_nxt;
			crLive_r <= crLive_nxt;
			bootFlag_r <= bootFlag_nxt;
			gateDrive_r <= gateDrive_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// copy-pulse request: self-clearing after one update cycle
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			copyPulseRequest_r <= 3'h0;
			currentReachedResult_r <= 3'h0;
		end else begin
			copyPulseRequest_r <= wrCopy ? wrData[2:0] : 3'h0; // see [R17]
			// result updated on dim fall or copy request
			currentReachedResult_r <= (currentReachedResult_r & ~(dimFall | copyPulseRequest_r))
				| (crLive_r & (dimFall | copyPulseRequest_r)); // see [R17]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read mux; reserved bits return zero, unmapped addresses read zero
	always @* begin
		rdWord = 8'h00;
		case (addr)
			`LDF_ADDR_DIAG2: rdWord = {5'h00, toggleFlag_r}; // see [R3]
			`LDF_ADDR_DIAG3: rdWord = {2'h0, crLive_r, headroomFlag_r}; // see [R11]
			`LDF_ADDR_BOOT: rdWord = {5'h00, bootFlag_r}; // see [R16]
			`LDF_ADDR_COPY: rdWord = {5'h00, copyPulseRequest_r};
			default: rdWord = 8'h00;
		endcase
	end

	ldf_read_reg uRead (
		.clk(clk),
		.arst_n(arst_n),
		.rdEn(rdEn),
		.rdWord(rdWord),
		.rdData_r(rdData)
	);
endmodule

// ### ldf_defines.vh
// register offsets, field positions and timing counts of the led diagnostic flag block
`ifndef LDF_DEFINES_VH
`define LDF_DEFINES_VH
`define LDF_ADDR_COPY 8'h06
`define LDF_ADDR_BOOT 8'h34
`define LDF_ADDR_DIAG3 8'h35
`define LDF_ADDR_DIAG2 8'h36
`define LDF_CR_LSB 3
`define LDF_HR_LSB 0
`define LDF_TOG_LSB 0
`define LDF_BOOT_LSB 0
`define LDF_FLAG_RESET 3'h0
`define LDF_GATE_MAX_NS 1000000
`define LDF_CLK_NS 10
`define LDF_GATE_MAX_CYC (`LDF_GATE_MAX_NS / `LDF_CLK_NS)
`endif

// ### ldf_read_reg.v
// small read-data register bank: holds the latched read word for the host port
`timescale 1ns/10ps
module ldf_read_reg (
	input wire clk,
	input wire arst_n,
	input wire rdEn,
	input wire [7:0] rdWord,
	output reg [7:0] rdData_r
);
	// latch the addressed word on a read strobe
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdData_r <= 8'h00;
		end else if (rdEn) begin
			rdData_r <= rdWord;
		end
	end
endmodule

// ### ldf_host_model.sv
// host model: drives single register reads and writes
`timescale 1ns/10ps
module ldf_host_model (
	input wire clk,
	input wire [7:0] rdData,
	output logic wrEn = 1'b0,
	output logic rdEn = 1'b0,
	output logic [7:0] addr = 8'h00,
	output logic [7:0] wrData = 8'h00
);
	// write: strobe held to the taking edge, then bus shows inverted values
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wrEn <= 1'b1;
		addr <= a;
		wrData <= d;
		@(posedge clk);
		wrEn <= 1'b0;
		addr <= ~a;
		wrData <= ~d;
	endtask
	// read: data lands on the taking edge
	task rd(input logic [7:0] a, output logic [7:0] q);
		@(posedge clk);
		rdEn <= 1'b1;
		addr <= a;
		@(posedge clk);
		rdEn <= 1'b0;
		addr <= ~a;
		#1 q = rdData;
	endtask
endmodule

// ### ldf_diag_flags_chk.sv
// assertion checker for the led diagnostic flag block
`timescale 1ns/10ps
`include "ldf_defines.vh"
module ldf_diag_chk (
	input wire clk,
	input wire arst_n,
	input wire wrEn,
	input wire rdEn,
	input wire [7:0] addr,
	input wire [7:0] wrData,
	input wire [7:0] rdData,
	input wire [2:0] channelOn,
	input wire inputSupplyOk,
	input wire [2:0] headroomLow,
	input wire [2:0] switchNodeOff,
	input wire [2:0] bootstrapBelowUv,
	input wire [2:0] gateDrive_r,
	input wire [2:0] copyPulseRequest_r
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// low bootstrap seen in off time, then a quiet bus up to a flag read
	sequence sBoot;
		bootstrapBelowUv[2] && switchNodeOff[2];
	endsequence
	sequence sBootRead;
		sBoot ##1 (!wrEn)[*5] ##1 (rdEn && !wrEn && addr == `LDF_ADDR_BOOT);
	endsequence
	AST_BOOT_BLOCK: assert property (sBoot |=> !gateDrive_r[2])
		else $error("gate on during bootstrap undervoltage");
	AST_BOOT_STICKY: assert property (sBootRead |=> rdData[2])
		else $error("bootstrap flag lost");
	AST_HEADROOM_OFF: assert property (
		channelOn[1] && inputSupplyOk && headroomLow[1] |=> !gateDrive_r[1])
		else $error("gate on during low headroom");
	AST_COPY_SET: assert property (
		wrEn && addr == `LDF_ADDR_COPY && wrData[1] |=> copyPulseRequest_r[1])
		else $error("copy request not raised");
	AST_COPY_SELF: assert property (
		copyPulseRequest_r[1] && !wrEn |=> !copyPulseRequest_r[1])
		else $error("copy request not self cleared");
	AST_RD_BOOT: assert property (
		rdEn && addr == `LDF_ADDR_BOOT |=> rdData[7:3] == 5'h00)
		else $error("boot register reserved bits set");
	AST_RD_DIAG3: assert property (
		rdEn && addr == `LDF_ADDR_DIAG3 |=> rdData[7:6] == 2'h0)
		else $error("diag3 reserved bits set");
	AST_RD_UNMAPPED: assert property (rdEn && addr == 8'h10 |=> rdData == 8'h00)
		else $error("unmapped read not zero");
	AST_RD_HOLD: assert property (!rdEn |=> $stable(rdData))
		else $error("read data moved without read");
endmodule
bind ldf_diag_flags ldf_diag_chk i_chk (.clk(clk), .arst_n(arst_n), .wrEn(wrEn), .rdEn(rdEn),
	.addr(addr), .wrData(wrData), .rdData(rdData), .channelOn(channelOn),
	.inputSupplyOk(inputSupplyOk), .headroomLow(headroomLow), .switchNodeOff(switchNodeOff),
	.bootstrapBelowUv(bootstrapBelowUv), .gateDrive_r(gateDrive_r),
	.copyPulseRequest_r(copyPulseRequest_r));

// ### test_led_channel_diag_flags.sv
// self-checking bench for the led diagnostic flag block
`timescale 1ns/10ps
`include "ldf_defines.vh"
module test_led_channel_diag_flags;
	logic clk = 0, arstN = 0, supOk = 0;
	logic [2:0] dim = 0, chOn = 0, hrLow = 0, tgt = 0, swOff = 0, bsUv = 0, gReq = 0;
	wire wrEn, rdEn;
	wire [7:0] addr, wrData, rdData;
	wire [2:0] gate, crRes, cpReq;
	int errCount = 0, cmpCount = 0, tog = 0, hr = 0, cr = 0, boot = 0;
	logic [7:0] q;
	always #5 clk = ~clk;
	ldf_host_model i_host (.clk(clk), .rdData(rdData), .wrEn(wrEn), .rdEn(rdEn), .addr(addr),
		.wrData(wrData));
	ldf_diag_flags i_dut (.clk(clk), .arst_n(arstN), .dimInput(dim), .channelOn(chOn),
		.inputSupplyOk(supOk), .headroomLow(hrLow), .targetReached(tgt), .switchNodeOff(swOff),
		.bootstrapBelowUv(bsUv), .gateRequest(gReq), .wrEn(wrEn), .rdEn(rdEn), .addr(addr),
		.wrData(wrData), .rdData(rdData), .gateDrive_r(gate), .currentReachedResult_r(crRes),
		.copyPulseRequest_r(cpReq));
	task completeRun;
		if (errCount == 0 && cmpCount > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		cmpCount++;
		if (g !== e) begin
			errCount++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	// read a register and compare with the model word
	task rc(input logic [7:0] a, input int e);
		i_host.rd(a, q);
		chk("rdData", e[7:0], q);
	endtask
	task st;
		repeat (4) @(posedge clk);
	endtask
	// watchdog well beyond the roughly one hundred cycles the sequence needs
	initial begin
		#200000;
		errCount++;
		completeRun;
	end
	initial begin
		void'($urandom(25));
		repeat (8) @(posedge clk);
		arstN <= 1;
		gReq <= 3'h7;
		supOk <= 1;
		chOn <= 3'h7;
		rc(`LDF_ADDR_BOOT, 0);
		rc(`LDF_ADDR_DIAG3, 0);
		rc(8'h10, 0);
		@(posedge clk) dim <= 3'h5;
		tog = 5;
		st;
		rc(`LDF_ADDR_DIAG2, tog);
		i_host.wr(`LDF_ADDR_DIAG2, 8'($urandom));
		tog = 0;
		rc(`LDF_ADDR_DIAG2, tog);
		@(posedge clk) begin
			dim <= 3'h7;
			tgt <= 3'h7;
		end
		cr = 7;
		st;
		rc(`LDF_ADDR_DIAG3, cr << 3);
		@(posedge clk) begin
			tgt <= 0;
			dim <= 3'h6;
		end
		cr = 6;
		st;
		rc(`LDF_ADDR_DIAG3, cr << 3);
		i_host.wr(`LDF_ADDR_COPY, 8'h02);
		cr = 4;
		st;
		chk("crRes", 8'h01, {7'h0, crRes[1]});
		rc(`LDF_ADDR_DIAG3, cr << 3);
		@(posedge clk) supOk <= 0;
		st;
		rc(`LDF_ADDR_DIAG3, 0);
		@(posedge clk) begin
			supOk <= 1;
			hrLow <= 3'h2;
		end
		hr = 2;
		st;
		@(posedge clk) hrLow <= 0;
		st;
		chk("gate", 8'h01, {7'h0, gate[1]});
		rc(`LDF_ADDR_DIAG3, hr);
		i_host.wr(`LDF_ADDR_DIAG3, 8'h00);
		rc(`LDF_ADDR_DIAG3, 0);
		@(posedge clk) begin
			bsUv <= 3'h4;
			swOff <= 3'h4;
		end
		st;
		@(posedge clk) bsUv <= 0;
		st;
		rc(`LDF_ADDR_BOOT, 4);
		chk("gate", 8'h00, {7'h0, gate[2]});
		i_host.wr(`LDF_ADDR_BOOT, 8'hFB);
		rc(`LDF_ADDR_BOOT, 4);
		i_host.wr(`LDF_ADDR_BOOT, 8'h04);
		rc(`LDF_ADDR_BOOT, 0);
		swOff <= 0;
		st;
		chk("gate", 8'h01, {7'h0, gate[2]});
		// stale low-headroom sample re-sets the flag of an off channel
		@(posedge clk) hrLow <= 3'h1;
		st;
		@(posedge clk) chOn <= 3'h6;
		i_host.wr(`LDF_ADDR_DIAG3, 8'h00);
		rc(`LDF_ADDR_DIAG3, 1);
		i_host.wr(8'h20, 8'($urandom));
		rc(8'h20, 0);
		completeRun;
	end
endmodule
